// ---- dv/slm_lcd_driver_props.sv ----
`timescale 1ns/1ps
`include "slm_defines.svh"

module slm_lcd_driver_props #(
  parameter int P_NPADS = 32
) (
  input wire logic                   i_clk_sys,
  input wire logic                   i_rst,
  input wire logic [`SLM_ADDR_W-1:0] i_addr,
  input wire logic [`SLM_DATA_W-1:0] i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [`SLM_DATA_W-1:0] o_rdata,
  input wire logic [2*P_NPADS-1:0]   o_seg_level,
  input wire logic [1:0]             o_common_line_0,
  input wire logic [P_NPADS-1:0]     o_pad_lcd_en,
  input wire logic                   o_frame_start,
  input wire logic                   o_waveform_active,
  input wire logic                   o_bias_run,
  input wire logic                   o_bias_half
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  logic [1:0] mux_q;
  logic [7:0] used_m;
  logic       ctrl_wr;

  // track the programmed selector, reads are masked by it at once
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mux_q <= 2'h0;
    end else if (ctrl_wr) begin
      mux_q <= i_wdata[1:0];
    end
  end

  // useful data bits per multiplex mode
  assign ctrl_wr = i_wr && (i_addr == `SLM_OFF_CTRL);
  assign used_m  = (mux_q == 2'h0) ? 8'h11 : (mux_q == 2'h1) ? 8'h33 :
                   (mux_q == 2'h2) ? 8'h77 : 8'hFF;

  sequence halt_req;
    ctrl_wr && i_wdata[`SLM_CTRL_HALT_BIT];
  endsequence
  sequence halted_quiet;
    (!o_waveform_active) [*2];
  endsequence

  chk_data_unused: assert property (
    i_rd && (i_addr < 5'h0F) |=> (o_rdata & ~used_m) == 8'h00)
    else $error("data read shows bits unused in this mode");
  chk_ctrl_fields: assert property (
    i_rd && (i_addr == `SLM_OFF_CTRL) |=>
      o_rdata[7:3] == 5'h00 && o_rdata[1:0] == mux_q)
    else $error("control read back has wrong fields");
  chk_idle_levels: assert property (
    halted_quiet |-> o_seg_level == '0 && o_common_line_0 == 2'h0)
    else $error("levels driven while waveforms stopped");
  chk_pad_route: assert property (
    i_wr && (i_addr == `SLM_OFF_PADSEL) |-> ##2
      o_pad_lcd_en[0] == $past(i_wdata[0], 2) &&
      o_pad_lcd_en[31] == $past(i_wdata[7], 2))
    else $error("pad mode does not follow pad select");
  chk_frame_spacing: assert property (
    o_frame_start |=> (!o_frame_start) [*3])
    else $error("frame start pulses too close");
  chk_bias_run: assert property (
    $past(i_wr, 2) && $past(i_addr, 2) == `SLM_OFF_BIAS |->
      o_bias_run == !($past(i_wdata[1], 2) || $past(i_wdata[3], 2)))
    else $error("bias run does not follow off and standby");
  chk_bias_mode: assert property (
    $past(i_wr, 2) && $past(i_addr, 2) == `SLM_OFF_BIAS |->
      o_bias_half == $past(i_wdata[2], 2))
    else $error("bias ratio does not follow mode bit");
  chk_halt_stop: assert property (
    halt_req |-> ##[1:600] !o_waveform_active)
    else $error("halt did not stop waveforms");
endmodule : slm_lcd_driver_props

bind slm_lcd_driver slm_lcd_driver_props #(.P_NPADS(P_NPADS)) u_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_seg_level(o_seg_level), .o_common_line_0(o_common_line_0),
  .o_pad_lcd_en(o_pad_lcd_en), .o_frame_start(o_frame_start),
  .o_waveform_active(o_waveform_active), .o_bias_run(o_bias_run),
  .o_bias_half(o_bias_half)
);

// ---- dv/slm_panel_model.sv ----
`timescale 1ns/1ps

module slm_panel_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_clear,
  input  wire logic [1:0] i_seg,
  input  wire logic [7:0] i_com,
  output logic      [3:0] o_lit
);
  logic [3:0] hit;

  // glass only lights at full drive: pad and common on opposite rails;
  // v1 against v2 is only a third of the swing, so it must not count
  assign hit[0] = (i_seg == ~i_com[1:0]) && (i_seg[1] == i_seg[0]);
  assign hit[1] = (i_seg == ~i_com[3:2]) && (i_seg[1] == i_seg[0]);
  assign hit[2] = (i_seg == ~i_com[5:4]) && (i_seg[1] == i_seg[0]);
  assign hit[3] = (i_seg == ~i_com[7:6]) && (i_seg[1] == i_seg[0]);

  // remember every segment seen lit since the last clear
  always_ff @(posedge i_clk_sys) begin
    if (i_clear) begin
      o_lit <= 4'h0;
    end else begin
      o_lit <= o_lit | hit;
    end
  end
endmodule : slm_panel_model

// ---- dv/test_slm_lcd_driver.sv ----
`timescale 1ns/1ps
`include "slm_defines.svh"

module test_slm_lcd_driver;
  localparam int SRC_CYC [4] = '{4, 5, 6, 7};

  typedef struct packed {
    logic [1:0] mux;
    logic [7:0] wdata;
    logic [7:0] exp_rd;
    logic [7:0] exp_rd15;
    logic [3:0] com_mask;
    logic [3:0] exp_lit;
  } slm_row_s;

  // mode, data, readback of reg 0 and reg 15, live commons, lit segments
  slm_row_s rows [5] = '{
    '{2'h0, 8'h5B, 8'h11, 8'h11, 4'h1, 4'h1},
    '{2'h1, 8'hFF, 8'h33, 8'h33, 4'h3, 4'h3},
    '{2'h1, 8'hC6, 8'h02, 8'h02, 4'h3, 4'h2},
    '{2'h2, 8'hFD, 8'h75, 8'h05, 4'h7, 4'h5},
    '{2'h3, 8'h0B, 8'h0B, 8'h00, 4'hF, 4'hB}
  };

  logic        i_clk_sys, i_rst, i_wr, i_rd, panel_clear;
  logic [4:0]  i_addr;
  logic [7:0]  i_wdata, rd;
  logic [7:0]  rdata;
  logic [63:0] seg_level;
  logic [1:0]  com0, com1, pump;
  logic [31:0] pad_en;
  logic [3:0]  lit;
  logic        frame_start, active, ref_en, run, off, half;
  int          fail_count, n_compared;

  always #4 i_clk_sys = ~i_clk_sys;

  slm_lcd_driver #(.P_SRC0_CYC(4), .P_SRC1_CYC(5), .P_SRC2_CYC(6),
    .P_SRC3_CYC(7), .P_NPADS(32)) dut_u (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .o_seg_level(seg_level), .o_common_line_0(com0),
    .o_common_line_1(com1), .o_pad_lcd_en(pad_en),
    .o_frame_start(frame_start), .o_waveform_active(active),
    .o_bias_internal_ref_en(ref_en), .o_bias_run(run),
    .o_bias_generator_off(off), .o_bias_half(half),
    .o_bias_pump_clock_sel(pump));

  // pad 31 and pad 30 stand in as third and fourth commons
  slm_panel_model panel_u (.i_clk_sys(i_clk_sys), .i_clear(panel_clear),
    .i_seg(seg_level[1:0]),
    .i_com({seg_level[61:60], seg_level[63:62], com1, com0}),
    .o_lit(lit));

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // bounded wait; sampling at the falling edge avoids edge races
  task automatic wait_frame;
    int n;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (frame_start !== 1'b1 && n < 1000);
    check("frame_start", frame_start, 1'b1);
  endtask : wait_frame

  task automatic measure(input logic [1:0] src, input logic [2:0] dv,
                         input logic [1:0] mux);
    int n;
    reg_wr(`SLM_OFF_FRAME, {dv, 3'h0, src});
    reg_wr(`SLM_OFF_CTRL, {6'h00, mux});
    wait_frame;
    wait_frame;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (frame_start !== 1'b1 && n < 5000);
    check("frame_period", n, 2 * (dv + 1) * (mux + 1) * SRC_CYC[src]);
  endtask : measure

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // a hang ends the run through the same closing task
  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end

  initial begin
    i_clk_sys = 1'b0;
    i_rst = 1'b1;
    i_addr = 5'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    panel_clear = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    reg_wr(`SLM_OFF_PADSEL, 8'hFF);
    reg_wr(`SLM_OFF_FRAME, 8'h00);
    #1 check("pad_en", pad_en, 32'hFFFFFFFF);
    // data only shows from a later frame, so let two frames pass
    foreach (rows[i]) begin
      reg_wr(`SLM_OFF_CTRL, {6'h00, rows[i].mux});
      reg_wr(`SLM_OFF_DATA0, rows[i].wdata);
      reg_wr(5'h0F, rows[i].wdata);
      wait_frame;
      wait_frame;
      @(posedge i_clk_sys) panel_clear <= 1'b1;
      @(posedge i_clk_sys) panel_clear <= 1'b0;
      wait_frame;
      wait_frame;
      check("panel_lit", lit & rows[i].com_mask, rows[i].exp_lit);
      reg_rd(`SLM_OFF_DATA0, rd);
      check("data_rd", rd, rows[i].exp_rd);
      reg_rd(5'h0F, rd);
      check("data15_rd", rd, rows[i].exp_rd15);
    end
    // reset in mid-run
    @(posedge i_clk_sys) i_rst <= 1'b1;
    @(negedge i_clk_sys);
    check("bias_off_rst", off, 1'b1);
    check("seg_rst", seg_level, 64'h0);
    @(posedge i_clk_sys) i_rst <= 1'b0;
    for (int a = 16; a < 21; a++) begin
      reg_rd(5'(a), rd);
      check("reg_rst", rd, 8'h00);
    end
    reg_wr(5'h14, 8'hFF);
    reg_rd(5'h14, rd);
    check("unmapped", rd, 8'h00);
    reg_wr(`SLM_OFF_PADSEL, 8'hFF);
    reg_wr(`SLM_OFF_FRAME, 8'hFF);
    reg_rd(`SLM_OFF_FRAME, rd);
    check("frame_cfg", rd, 8'hE3);
    reg_wr(`SLM_OFF_CTRL, 8'hFF);
    reg_rd(`SLM_OFF_CTRL, rd);
    check("ctrl", rd, 8'h07);
    reg_wr(`SLM_OFF_BIAS, 8'hF5);
    repeat (2) @(negedge i_clk_sys);
    check("bias_a", {ref_en, run, off, half, pump}, 6'b110111);
    reg_rd(`SLM_OFF_BIAS, rd);
    check("bias_rd", rd, 8'h35);
    reg_wr(`SLM_OFF_BIAS, 8'h0A);
    repeat (2) @(negedge i_clk_sys);
    check("bias_b", {ref_en, run, off, half, pump}, 6'b001000);
    // halt mid-frame: the frame finishes first, then all rails drop
    reg_wr(`SLM_OFF_FRAME, 8'h00);
    reg_wr(`SLM_OFF_CTRL, 8'h01);
    wait_frame;
    reg_wr(`SLM_OFF_CTRL, 8'h05);
    @(negedge i_clk_sys);
    check("halt_late", active, 1'b1);
    for (int n = 0; n < 100 && active === 1'b1; n++) @(negedge i_clk_sys);
    repeat (2) @(negedge i_clk_sys);
    check("halt_lvl", {active, com0, com1}, 5'h00);
    check("halt_seg", seg_level, 64'h0);
    reg_wr(`SLM_OFF_DATA0, 8'hAB);
    repeat (2) @(negedge i_clk_sys);
    reg_rd(`SLM_OFF_DATA0, rd);
    check("halt_data", rd, 8'h23);
    measure(2'h1, 3'h2, 2'h2);
    measure(2'h3, 3'h7, 2'h3);
    measure(2'h0, 3'h0, 2'h0);
    report_and_stop;
  end
endmodule : test_slm_lcd_driver

// ---- inc/slm_defines.svh ----
`ifndef SLM_DEFINES_SVH
`define SLM_DEFINES_SVH

// register bus geometry
`define SLM_ADDR_W         5
`define SLM_DATA_W         8
`define SLM_DATA_REGS      16

// register offsets
`define SLM_OFF_DATA0      5'h00
`define SLM_OFF_CTRL       5'h10
`define SLM_OFF_PADSEL     5'h11
`define SLM_OFF_FRAME      5'h12
`define SLM_OFF_BIAS       5'h13

// display_control_reg fields
`define SLM_CTRL_MUX_LSB   0
`define SLM_CTRL_HALT_BIT  2
`define SLM_CTRL_MASK      8'h07
`define SLM_CTRL_RST       8'h00

// pad_function_select_reg
`define SLM_PADSEL_ALL     8'hFF
`define SLM_PADSEL_RST     8'h00
`define SLM_PADS_PER_BIT   4

// frame_clock_cfg_reg fields
`define SLM_FRAME_SRC_LSB  0
`define SLM_FRAME_DIV_LSB  5
`define SLM_FRAME_MASK     8'hE3
`define SLM_FRAME_RST      8'h00

// bias_generator_cfg_reg fields
`define SLM_BIAS_REF_BIT   0
`define SLM_BIAS_OFF_BIT   1
`define SLM_BIAS_MODE_BIT  2
`define SLM_BIAS_STDB_BIT  3
`define SLM_BIAS_CLK_LSB   4
`define SLM_BIAS_MASK      8'h3F
`define SLM_BIAS_RST       8'h00

// segment data reset and per-mode useful bits
`define SLM_DATA_RST       8'h00
`define SLM_DMASK_DD       8'h11
`define SLM_DMASK_2        8'h33
`define SLM_DMASK_3        8'h77
`define SLM_DMASK_4        8'hFF
`define SLM_DMASK_LAST_3   8'h07
`define SLM_DMASK_LAST_4   8'h00

// timing: system clock and frame source frequencies in Hz
`define SLM_CLK_PERIOD_NS  8
`define SLM_CLK_HZ         125000000
`define SLM_SRC0_HZ        512
`define SLM_SRC1_HZ        1048
`define SLM_SRC2_HZ        2048
`define SLM_SRC3_HZ        4096
`define SLM_PRESCALE_W     18

// drive level codes, V0 lowest to V3 highest
`define SLM_LVL_V0         2'h0
`define SLM_LVL_V1         2'h1
`define SLM_LVL_V2         2'h2
`define SLM_LVL_V3         2'h3

`endif

// ---- inc/slm_pkg.sv ----
package slm_pkg;

  // multiplex scheme selector codes
  typedef enum logic [1:0] {
    SLM_MUX_DD = 2'b00,
    SLM_MUX_2  = 2'b01,
    SLM_MUX_3  = 2'b10,
    SLM_MUX_4  = 2'b11
  } slm_mux_e;

  // waveform sequencer state
  typedef enum logic {
    SLM_ST_IDLE = 1'b0,
    SLM_ST_RUN  = 1'b1
  } slm_state_e;

  typedef logic [1:0] slm_level_t;

endpackage : slm_pkg

// ---- verilog/slm_frame_tick.sv ----
`timescale 1ns/1ps
`include "slm_defines.svh"

module slm_frame_tick #(
  parameter int P_SRC0_CYC = `SLM_CLK_HZ / `SLM_SRC0_HZ,
  parameter int P_SRC1_CYC = `SLM_CLK_HZ / `SLM_SRC1_HZ,
  parameter int P_SRC2_CYC = `SLM_CLK_HZ / `SLM_SRC2_HZ,
  parameter int P_SRC3_CYC = `SLM_CLK_HZ / `SLM_SRC3_HZ
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [1:0] i_src_sel,
  input  wire logic [2:0] i_div_sel,
  output logic            o_half_tick
);

  logic [`SLM_PRESCALE_W-1:0] pre_cnt;
  logic [2:0]                 div_cnt;
  wire  [`SLM_PRESCALE_W-1:0] period_m1;
  wire                        pre_wrap;
  wire                        div_wrap;

  // source period select; each source is a whole number of system cycles
  assign period_m1 =
    (i_src_sel == 2'h0) ? `SLM_PRESCALE_W'(P_SRC0_CYC - 1) :
    (i_src_sel == 2'h1) ? `SLM_PRESCALE_W'(P_SRC1_CYC - 1) :
    (i_src_sel == 2'h2) ? `SLM_PRESCALE_W'(P_SRC2_CYC - 1) :
                          `SLM_PRESCALE_W'(P_SRC3_CYC - 1);
  assign pre_wrap = (pre_cnt >= period_m1);
  assign div_wrap = (div_cnt >= i_div_sel);

  // prescaler then divide by code plus one; both held clear while stopped
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt     <= '0;
      div_cnt     <= 3'h0;
      o_half_tick <= 1'b0;
    end else if (!i_run) begin
      pre_cnt     <= '0;
      div_cnt     <= 3'h0;
      o_half_tick <= 1'b0;
    end else begin
      pre_cnt     <= pre_wrap ? '0 : pre_cnt + 1'b1;
      div_cnt     <= !pre_wrap ? div_cnt : (div_wrap ? 3'h0 : div_cnt + 3'h1);
      o_half_tick <= pre_wrap && div_wrap; // R15
    end
  end

endmodule : slm_frame_tick

// ---- verilog/slm_lcd_driver.sv ----
`timescale 1ns/1ps
`include "slm_defines.svh"

// How it works
// R1: 1:2 mode drives two segments per pin against common lines 0 and 1.
// R2: 1:2 mode uses data bits 0,1 and 4,5 only.
// R3: selector code 01 gives 1:2, 10 gives 1:3, 11 gives 1:4.
// R4: 1:3 drives segments on pins 30..0; pin 31 carries the third common.
// R5: 1:3 mode uses data bits 0..2 and 4..6; bits 3 and 7 ignored.
// R6: 1:4 drives pins 29..0; pins 31 and 30 carry commons three and four.
// R7: 1:4 mode uses all eight data bits, one per segment.
// R8: waveforms run only while the halt bit is zero.
// R9: pad select all ones routes waveforms to every pad.
// R10: bias mode bit one selects half bias, zero third bias.
// R11: bias runs with off and standby zero; ref enable picks internal ref.
// R12: frame rate set by source and divider select fields.
// R13: data bit one turns segment on; low nibble even pin, high odd pin.
// R14: selector code 00 gives direct drive against common line 0.
// R15: frame rate is source over twice divider times multiplex factor.
// R16: data writes apply at next frame start; unused bits read zero.
// R17: halt stops at frame end; data writes still accepted.
// R18: control holds mux in 1:0, halt in 2; frame cfg div 7:5, src 1:0.
// R19: commons rotate in fixed order, each an equal share of the frame.

module slm_lcd_driver #(
  parameter int P_SRC0_CYC = `SLM_CLK_HZ / `SLM_SRC0_HZ,
  parameter int P_SRC1_CYC = `SLM_CLK_HZ / `SLM_SRC1_HZ,
  parameter int P_SRC2_CYC = `SLM_CLK_HZ / `SLM_SRC2_HZ,
  parameter int P_SRC3_CYC = `SLM_CLK_HZ / `SLM_SRC3_HZ,
  parameter int P_NPADS    = 32
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst,
  input  wire logic [`SLM_ADDR_W-1:0] i_addr,
  input  wire logic [`SLM_DATA_W-1:0] i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic [`SLM_DATA_W-1:0]     o_rdata,
  output logic [2*P_NPADS-1:0]       o_seg_level,
  output logic [1:0]                 o_common_line_0,
  output logic [1:0]                 o_common_line_1,
  output logic [P_NPADS-1:0]         o_pad_lcd_en,
  output logic                       o_frame_start,
  output logic                       o_waveform_active,
  output logic                       o_bias_internal_ref_en,
  output logic                       o_bias_run,
  output logic                       o_bias_generator_off,
  output logic                       o_bias_half,
  output logic [1:0]                 o_bias_pump_clock_sel
);

  localparam int NREG = `SLM_DATA_REGS;

  // software-visible registers
  logic [7:0] display_control_reg;
  logic [7:0] pad_function_select_reg;
  logic [7:0] frame_clock_cfg_reg;
  logic [7:0] bias_generator_cfg_reg;
  logic [7:0] segment_data_reg [NREG];
  // copy on the glass, refreshed at frame boundaries and on every cycle while idle
  logic [7:0] shown_data       [NREG];

  // sequencer state
  slm_pkg::slm_state_e state;
  slm_pkg::slm_mux_e   cur_mux;
  logic [1:0]          phase;
  logic                pol;

  wire                 half_tick;
  wire                 running;
  wire                 frame_end;
  wire                 load_frame;
  wire                 waveform_halt;
  wire                 third_bias;
  wire [1:0]           multiplex_scheme_sel;
  wire [1:0]           frame_source_sel;
  wire [2:0]           frame_divider_sel;
  wire                 pads_lcd_mode;

  // register field decode
  assign multiplex_scheme_sel =
    display_control_reg[`SLM_CTRL_MUX_LSB +: 2];        // R18
  assign waveform_halt = display_control_reg[`SLM_CTRL_HALT_BIT]; // R18
  assign frame_source_sel =
    frame_clock_cfg_reg[`SLM_FRAME_SRC_LSB +: 2];       // R18
  assign frame_divider_sel =
    frame_clock_cfg_reg[`SLM_FRAME_DIV_LSB +: 3];       // R18

  // address decode for the plain register port
  wire hit_data   = (i_addr < `SLM_ADDR_W'(NREG));
  wire hit_ctrl   = (i_addr == `SLM_OFF_CTRL);
  wire hit_padsel = (i_addr == `SLM_OFF_PADSEL);
  wire hit_frame  = (i_addr == `SLM_OFF_FRAME);
  wire hit_bias   = (i_addr == `SLM_OFF_BIAS);
  wire [3:0] data_idx = i_addr[3:0];

  // register writes; data stays writable while halted
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      display_control_reg     <= `SLM_CTRL_RST;
      pad_function_select_reg <= `SLM_PADSEL_RST;
      frame_clock_cfg_reg     <= `SLM_FRAME_RST;
      bias_generator_cfg_reg  <= `SLM_BIAS_RST;
    end else if (i_wr) begin
      if (hit_ctrl)
        display_control_reg <= i_wdata & `SLM_CTRL_MASK;
      if (hit_padsel)
        pad_function_select_reg <= i_wdata;
      if (hit_frame)
        frame_clock_cfg_reg <= i_wdata & `SLM_FRAME_MASK;
      if (hit_bias)
        bias_generator_cfg_reg <= i_wdata & `SLM_BIAS_MASK;
    end
  end

  // segment data store, one writer per entry
  generate
    for (genvar r = 0; r < NREG; r++) begin : g_data
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          segment_data_reg[r] <= `SLM_DATA_RST;
        end else if (i_wr && hit_data && data_idx == 4'(r)) begin
          segment_data_reg[r] <= i_wdata; // R17
        end
      end
      // shown copy follows the store only at frame start or when idle
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          shown_data[r] <= `SLM_DATA_RST;
        end else if (load_frame) begin
          shown_data[r] <= segment_data_reg[r]; // R16
        end
      end
    end
  endgenerate

  // useful-bit mask by programmed scheme; the last register loses the
  // nibbles whose pins became commons
  wire [7:0] mode_mask =
    (multiplex_scheme_sel == slm_pkg::SLM_MUX_DD) ? `SLM_DMASK_DD :
    (multiplex_scheme_sel == slm_pkg::SLM_MUX_2)  ? `SLM_DMASK_2  : // R2
    (multiplex_scheme_sel == slm_pkg::SLM_MUX_3)  ? `SLM_DMASK_3  : // R5
                                                    `SLM_DMASK_4;   // R7
  wire [7:0] last_mask =
    (multiplex_scheme_sel == slm_pkg::SLM_MUX_3) ? `SLM_DMASK_LAST_3 :
    (multiplex_scheme_sel == slm_pkg::SLM_MUX_4) ? `SLM_DMASK_LAST_4 :
                                                   mode_mask;
  wire [7:0] data_mask = (data_idx == 4'(NREG - 1)) ? last_mask : mode_mask;

  // read back shows what is on the glass, unused bits as zero
  wire [7:0] rd_value =
    hit_data   ? (shown_data[data_idx] & data_mask) : // R16
    hit_ctrl   ? display_control_reg :
    hit_padsel ? pad_function_select_reg :
    hit_frame  ? frame_clock_cfg_reg :
    hit_bias   ? bias_generator_cfg_reg :
                 8'h00;

  // read data valid in the cycle after the strobe only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_value : 8'h00;
    end
  end

  // half-period ticks; each common phase spans two half periods
  slm_frame_tick #(
    .P_SRC0_CYC (P_SRC0_CYC),
    .P_SRC1_CYC (P_SRC1_CYC),
    .P_SRC2_CYC (P_SRC2_CYC),
    .P_SRC3_CYC (P_SRC3_CYC)
  ) u_tick (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_run       (running),
    .i_src_sel   (frame_source_sel),   // R12
    .i_div_sel   (frame_divider_sel),  // R12
    .o_half_tick (half_tick)
  );

  // frame ends after the last phase's second half; the phase count is
  // the selector code plus one, so direct drive has one phase
  assign running   = (state == slm_pkg::SLM_ST_RUN);
  assign frame_end = running && half_tick && pol &&
                     (phase == 2'(cur_mux));
  assign load_frame = !running || frame_end; // R16

  // sequencer: halt is sampled only at frame end, so a frame never cuts off
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state   <= slm_pkg::SLM_ST_IDLE;
      cur_mux <= slm_pkg::SLM_MUX_DD;
      phase   <= 2'h0;
      pol     <= 1'b0;
    end else begin
      unique case (state)
        slm_pkg::SLM_ST_IDLE: begin
          phase   <= 2'h0;
          pol     <= 1'b0;
          cur_mux <= slm_pkg::slm_mux_e'(multiplex_scheme_sel); // R3
          if (!waveform_halt) begin
            state <= slm_pkg::SLM_ST_RUN; // R8
          end
        end
        slm_pkg::SLM_ST_RUN: begin
          if (half_tick) begin
            pol <= !pol;
            if (frame_end) begin
              phase   <= 2'h0;
              cur_mux <= slm_pkg::slm_mux_e'(multiplex_scheme_sel);
              if (waveform_halt) begin
                state <= slm_pkg::SLM_ST_IDLE; // R17
              end
            end else if (pol) begin
              phase <= phase + 2'h1; // R19
            end
          end
        end
      endcase
    end
  end

  // direct drive keeps one level pair; 1:2 half bias; 1:3 and 1:4 third
  assign third_bias = (cur_mux == slm_pkg::SLM_MUX_3) ||
                      (cur_mux == slm_pkg::SLM_MUX_4);

  // common waveforms: active common swings to the rail opposite the phase
  // polarity; idle commons sit mid-way so unselected segments see little
  slm_pkg::slm_level_t com_lvl [4];
  generate
    for (genvar k = 0; k < 4; k++) begin : g_com
      wire com_used = (k == 0) || (2'(k) <= 2'(cur_mux)); // R14
      wire com_act  = (phase == 2'(k));                    // R19
      assign com_lvl[k] =
        (!running || !com_used) ? `SLM_LVL_V0 :
        com_act    ? (pol ? `SLM_LVL_V0 : `SLM_LVL_V3) :
        third_bias ? (pol ? `SLM_LVL_V2 : `SLM_LVL_V1) :
                     `SLM_LVL_V2;
    end
  endgenerate

  // segment levels; each data register serves an even and an odd pin
  wire [2*P_NPADS-1:0] seg_lvl;
  wire [2*P_NPADS-1:0] pad_lvl;
  generate
    for (genvar p = 0; p < P_NPADS; p++) begin : g_seg
      wire [3:0] nib = (p % 2 == 1) ? shown_data[p / 2][7:4] // R13
                            : shown_data[p / 2][3:0];
      slm_seg_cell u_cell (
        .i_active (running),
        .i_data   (nib),    // R1
        .i_phase  (phase),
        .i_pol    (pol),
        .i_third  (third_bias),
        .o_level  (seg_lvl[2*p +: 2])
      );
    end
  endgenerate

  // pin 31 turns into common three in 1:3 and 1:4; pin 30 turns into common four in 1:4 only
  wire pin31_com = (cur_mux == slm_pkg::SLM_MUX_3) ||
                   (cur_mux == slm_pkg::SLM_MUX_4);       // R4
  wire pin30_com = (cur_mux == slm_pkg::SLM_MUX_4);       // R6
  assign pad_lvl[2*P_NPADS-1 -: 2] =
    pin31_com ? com_lvl[2] : seg_lvl[2*P_NPADS-1 -: 2];   // R4
  assign pad_lvl[2*P_NPADS-3 -: 2] =
    pin30_com ? com_lvl[3] : seg_lvl[2*P_NPADS-3 -: 2];   // R6
  assign pad_lvl[2*P_NPADS-5:0] = seg_lvl[2*P_NPADS-5:0];

  // pad routing: each select bit owns a group of four pads
  assign pads_lcd_mode = (pad_function_select_reg == `SLM_PADSEL_ALL);
  wire [P_NPADS-1:0] next_pad_en;
  generate
    for (genvar q = 0; q < P_NPADS; q++) begin : g_pad
      assign next_pad_en[q] =
        pad_function_select_reg[q / `SLM_PADS_PER_BIT]; // R9
    end
  endgenerate

  // registered pin drive, so pad levels never glitch between phases
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_seg_level       <= '0;
      o_common_line_0   <= `SLM_LVL_V0;
      o_common_line_1   <= `SLM_LVL_V0;
      o_pad_lcd_en      <= '0;
      o_frame_start     <= 1'b0;
      o_waveform_active <= 1'b0;
    end else begin
      o_seg_level       <= pad_lvl;
      o_common_line_0   <= com_lvl[0];        // R14
      o_common_line_1   <= com_lvl[1];        // R1
      o_pad_lcd_en      <= next_pad_en;       // R9
      o_frame_start     <= load_frame && !waveform_halt && pads_lcd_mode;
      o_waveform_active <= running;           // R8
    end
  end

  // bias generator controls; the analog side acts on these levels
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_bias_internal_ref_en <= 1'b0;
      o_bias_run             <= 1'b0;
      o_bias_generator_off   <= 1'b1;
      o_bias_half            <= 1'b0;
      o_bias_pump_clock_sel  <= 2'h0;
    end else begin
      o_bias_internal_ref_en <=
        bias_generator_cfg_reg[`SLM_BIAS_REF_BIT];     // R11
      o_bias_run <= !bias_generator_cfg_reg[`SLM_BIAS_OFF_BIT] &&
                    !bias_generator_cfg_reg[`SLM_BIAS_STDB_BIT]; // R11
      o_bias_generator_off <=
        bias_generator_cfg_reg[`SLM_BIAS_OFF_BIT];     // R11
      o_bias_half <= bias_generator_cfg_reg[`SLM_BIAS_MODE_BIT]; // R10
      o_bias_pump_clock_sel <=
        bias_generator_cfg_reg[`SLM_BIAS_CLK_LSB +: 2]; // R11
    end
  end

endmodule : slm_lcd_driver

// ---- verilog/slm_seg_cell.sv ----
`timescale 1ns/1ps
`include "slm_defines.svh"

module slm_seg_cell (
  input  wire logic       i_active,
  input  wire logic [3:0] i_data,
  input  wire logic [1:0] i_phase,
  input  wire logic       i_pol,
  input  wire logic       i_third,
  output logic [1:0]      o_level
);

  wire seg_on;

  // one data bit per common phase, 1 means segment on
  assign seg_on = i_data[i_phase]; // R13

  // on: opposite of the active common; off: near it, so the net stays small
  assign o_level = !i_active ? `SLM_LVL_V0 :
                   seg_on    ? (i_pol ? `SLM_LVL_V3 : `SLM_LVL_V0) :
                   i_third   ? (i_pol ? `SLM_LVL_V1 : `SLM_LVL_V2) :
                               (i_pol ? `SLM_LVL_V0 : `SLM_LVL_V3);

endmodule : slm_seg_cell
